/* pkg/atpw_defs.svh */
`ifndef ATPW_DEFS_SVH
`define ATPW_DEFS_SVH

// Gain is in hundredths: 1000 means 10.00
`define ATPW_GAIN_MAX 16'sd1000
`define ATPW_GAIN_MIN -16'sd1000
`define ATPW_LIMIT_MAX 32'sd20000
`define ATPW_LIMIT_MIN -32'sd20000
`define ATPW_GAIN_SCALE 48'sd100
// Timebase: reference cycles per period unit, 40 MHz / 1 kHz = 1 ms units
`define ATPW_REF_CLK_HZ 40000000
`define ATPW_UNIT_HZ 1000
`define ATPW_UNIT_CYCLES (`ATPW_REF_CLK_HZ / `ATPW_UNIT_HZ)

`endif

/* pkg/atpw_pkg.sv */
package atpw_pkg;
  typedef enum logic [1:0] {
    ATPW_IDLE = 2'b00,
    ATPW_RUN = 2'b01
  } atpw_state_t;
endpackage

/* src/atpw_modulator.sv */
`include "atpw_defs.svh"

module atpw_modulator #(
  parameter int VAL_W = 16,
  parameter int PER_W = 16,
  parameter int UNIT_CYCLES = `ATPW_UNIT_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic signed [VAL_W-1:0] analog_input_value_i,
  input wire logic signed [15:0] gain_i,
  input wire logic signed [VAL_W-1:0] offset_i,
  input wire logic signed [VAL_W-1:0] range_low_i,
  input wire logic signed [VAL_W-1:0] range_high_i,
  input wire logic [PER_W-1:0] period_i,
  input wire logic [1:0] decimals_i,
  output logic pulse_o,
  output logic running_o
);
  localparam int UW = $clog2(UNIT_CYCLES + 1);
  localparam int CW = 48;

  // Last reference cycle of one timebase unit
  localparam logic [UW-1:0] UNIT_LAST = UW'(UNIT_CYCLES - 1);

  // Enable edge group
  logic en_q;
  logic en_d;
  logic rise_c;

  // Share group: registered so the divider gets a whole cycle
  logic [PER_W-1:0] high_q;
  logic [PER_W-1:0] high_d;

  // Period timing group
  atpw_pkg::atpw_state_t st_q;
  atpw_pkg::atpw_state_t st_d;
  logic [UW-1:0] pre_q;
  logic [UW-1:0] pre_d;
  logic [PER_W-1:0] tick_q;
  logic [PER_W-1:0] tick_d;
  logic pulse_q;
  logic pulse_d;
  logic run_q;
  logic run_d;
  logic last_unit_c;

  // Wide enough that product and period scaling never wrap
  logic signed [CW-1:0] ain_w;
  logic signed [CW-1:0] off_w;
  logic signed [CW-1:0] per_w;
  logic signed [CW-1:0] gain_c;
  logic signed [CW-1:0] low_c;
  logic signed [CW-1:0] high_c;
  logic signed [CW-1:0] scaled;
  logic signed [CW-1:0] num;
  logic signed [CW-1:0] den;
  logic signed [CW-1:0] quot;

  function automatic logic signed [CW-1:0] clamp(
    input logic signed [CW-1:0] v,
    input logic signed [CW-1:0] lo,
    input logic signed [CW-1:0] hi
  );
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Gain in hundredths; division truncates toward zero
  function automatic logic signed [CW-1:0] scale(
    input logic signed [CW-1:0] a,
    input logic signed [CW-1:0] g,
    input logic signed [CW-1:0] o
  );
    scale = (a * g) / `ATPW_GAIN_SCALE + o;
  endfunction

  // Period 0 wraps every unit, so the output never rises
  function automatic logic [PER_W-1:0] next_tick(
    input logic [PER_W-1:0] t,
    input logic [PER_W-1:0] p
  );
    next_tick = ((t + 1'b1) >= p) ? '0 : t + 1'b1;
  endfunction

  always_comb begin
    en_d = enable_i;
    rise_c = enable_i && !en_q;
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      en_q <= 1'b0;
    end else begin
      en_q <= en_d;
    end
  end

  // Decimals input is deliberately not used here
  always_comb begin
    ain_w = CW'(analog_input_value_i);
    off_w = CW'(offset_i);
    per_w = CW'($signed({1'b0, period_i}));

    gain_c = clamp(CW'(gain_i), CW'(`ATPW_GAIN_MIN), CW'(`ATPW_GAIN_MAX));
    low_c = clamp(CW'(range_low_i), CW'(`ATPW_LIMIT_MIN), CW'(`ATPW_LIMIT_MAX));
    high_c = clamp(CW'(range_high_i), CW'(`ATPW_LIMIT_MIN), CW'(`ATPW_LIMIT_MAX));

    scaled = scale(ain_w, gain_c, off_w);
    num = scaled - low_c;
    den = high_c - low_c;

    quot = '0;
    if (den > 0) begin
      quot = (num * per_w) / den;
    end

    if (scaled <= low_c) begin
      high_d = '0;
    end else if (scaled >= high_c) begin
      high_d = period_i;
    end else begin
      high_d = quot[PER_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      high_q <= '0;
    end else begin
      high_q <= high_d;
    end
  end

  always_comb begin
    st_d = st_q;
    pre_d = pre_q;
    tick_d = tick_q;
    pulse_d = 1'b0;
    last_unit_c = (pre_q == UNIT_LAST);

    case (st_q)
      atpw_pkg::ATPW_IDLE: begin
        // start only on a fresh edge
        if (rise_c) begin
          st_d = atpw_pkg::ATPW_RUN;
          pre_d = '0;
          tick_d = '0;
          pulse_d = (high_q != '0);
        end
      end
      atpw_pkg::ATPW_RUN: begin
        if (!enable_i) begin
          st_d = atpw_pkg::ATPW_IDLE;
        end else begin
          if (last_unit_c) begin
            pre_d = '0;
            tick_d = next_tick(tick_q, period_i);
          end else begin
            pre_d = pre_q + 1'b1;
          end
          pulse_d = (tick_d < high_q);
        end
      end
      default: begin
        st_d = atpw_pkg::ATPW_IDLE;
      end
    endcase

    // Status comes from a flop, not a state decode
    run_d = (st_d == atpw_pkg::ATPW_RUN);
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q <= atpw_pkg::ATPW_IDLE;
      pre_q <= '0;
      tick_q <= '0;
      pulse_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pre_q <= pre_d;
      tick_q <= tick_d;
      pulse_q <= pulse_d;
      run_q <= run_d;
    end
  end

  // Both outputs straight from flops
  assign pulse_o = pulse_q;

  assign running_o = run_q;

endmodule // atpw_modulator

/* tb/atpw_asserts.sv */
module atpw_asserts (
  input logic ref_clk_i, reset_i, enable_i, pulse_o, running_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  a_start_on_rise: assert property ($rose(enable_i) |=> running_o) else $error("no start");
  a_start_cause: assert property ($rose(running_o) |-> $past(enable_i)) else $error("cause");
  a_idle_stop: assert property (!enable_i |=> !running_o) else $error("still running");
  a_idle_low: assert property (!enable_i |=> !pulse_o) else $error("pulse in idle");
  a_run_holds: assert property (running_o && enable_i |=> running_o) else $error("dropped");
  a_pulse_gated: assert property (pulse_o |-> running_o) else $error("stray pulse");
  a_stop_clear: assert property ($fell(running_o) |-> !pulse_o) else $error("pulse kept");
  a_stop_seq: assert property (running_o ##1 !running_o |-> !pulse_o) else $error("tail");
  cover property ($rose(running_o));
  cover property ($rose(pulse_o));
  cover property ($fell(pulse_o) && running_o);
endmodule // atpw_asserts
bind atpw_modulator atpw_asserts u_atpw_asserts (.*);

/* tb/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 0, reset_i = 1, enable_i = 0, pulse_o, running_o;
  logic signed [15:0] analog_input_value_i = 0, gain_i = 0, offset_i = 0;
  logic signed [15:0] range_low_i = 0, range_high_i = 0;
  logic [15:0] period_i = 0;
  logic [1:0] decimals_i = 0;
  int n_errors = 0, checks_done = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  // Short timebase unit keeps periods to a few dozen cycles
  atpw_modulator #(.UNIT_CYCLES(4)) u_atpw_modulator (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .enable_i(enable_i),
    .analog_input_value_i(analog_input_value_i),
    .gain_i(gain_i),
    .offset_i(offset_i),
    .range_low_i(range_low_i),
    .range_high_i(range_high_i),
    .period_i(period_i),
    .decimals_i(decimals_i),
    .pulse_o(pulse_o),
    .running_o(running_o)
  );
  task automatic conclude;
    $display("err %0d chk %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      n_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // Two whole periods counted, so a missed wrap shows up
  task automatic run_pwm(input logic signed [15:0] a, g, o, l, h, input logic [15:0] p, e);
    int hc;
    hc = 0;
    @(negedge ref_clk_i);
    {analog_input_value_i, gain_i, offset_i, range_low_i, range_high_i} = {a, g, o, l, h};
    period_i = p;
    decimals_i = decimals_i + 2'h1;
    @(negedge ref_clk_i);
    enable_i = 1;
    repeat (8 * p) begin
      @(negedge ref_clk_i);
      hc += (pulse_o === 1'b1);
    end
    check(hc == 8 * e && running_o === 1'b1, "high time");
    enable_i = 0;
    @(negedge ref_clk_i);
    check(pulse_o === 1'b0 && running_o === 1'b0, "stop");
  endtask
  task automatic t_ratio;
    run_pwm(500, 100, 0, 0, 1000, 4, 2);
    run_pwm(300, 100, 0, 0, 1000, 10, 3);
    run_pwm(-10, -1000, 200, 0, 1000, 10, 3);
    run_pwm(20, 1000, 0, 0, 1000, 10, 2);
    run_pwm(20, 1500, 0, 0, 1000, 10, 2);
  endtask
  task automatic t_saturate;
    run_pwm(0, 100, -5, 0, 1000, 4, 0);
    run_pwm(1000, 100, 0, 0, 1000, 4, 4);
    run_pwm(0, 100, 0, -20000, 20000, 8, 4);
  endtask
  initial begin
    repeat (6) @(negedge ref_clk_i);
    reset_i = 0;
    t_ratio();
    t_saturate();
    conclude();
  end
  initial begin
    #100us;
    n_errors++;
    conclude();
  end
endmodule // tb_top
